// >>> ilcc_defs.svh
`ifndef ILCC_DEFS_SVH
`define ILCC_DEFS_SVH

// ---------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------------------
`define ILCC_IDX_LENGTHS     12'h115
`define ILCC_IDX_GEN_BITS    12'h116
`define ILCC_IDX_ACT_BITS    12'h117
`define ILCC_IDX_GEN_CTRL    12'h118
`define ILCC_CHAN_STRIDE     12'h040
`define ILCC_CHAN_BASE       12'h100

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define ILCC_GEN_LEN_LSB     4
`define ILCC_ACT_LEN_LSB     2
`define ILCC_DEACT_LEN_LSB   0
`define ILCC_GEN_EN_BIT      0
`define ILCC_GEN_BUSY_BIT    1

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define ILCC_RST_LENGTHS     8'h01
`define ILCC_RST_GEN_BITS    8'h01
`define ILCC_RST_ACT_BITS    8'h00

// ---------------------------------------------------------------------------
// Code length encoding
// ---------------------------------------------------------------------------
`define ILCC_MIN_CODE_LEN    4'h5

`endif

// >>> ilcc_pkg.sv
`default_nettype none
package ilcc_pkg;
   typedef logic [1:0] ilcc_len_t;
   typedef logic [7:0] ilcc_byte_t;
   typedef enum logic [1:0] {ILCC_IDLE, ILCC_SEND} ilcc_gen_state_e;
endpackage
`default_nettype wire

// >>> ilcc_chan_if.sv
`default_nettype none
interface ilcc_chan_if;
   import ilcc_pkg::*;
   ilcc_len_t  gen_len;
   ilcc_byte_t gen_bits;
   logic       gen_en;
   logic       tx_bit;
   logic       tx_valid;
   logic       busy;
   modport bank (output gen_len, output gen_bits, output gen_en,
                 input tx_bit, input tx_valid, input busy);
   modport gen  (input gen_len, input gen_bits, input gen_en,
                 output tx_bit, output tx_valid, output busy);
endinterface
`default_nettype wire

// >>> ilcc_code_gen.sv
`default_nettype none
`include "ilcc_defs.svh"
module ilcc_code_gen
   import ilcc_pkg::*;
(
   // Clock, reset and enable
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic clk_en,
   // Channel settings and serial code
   ilcc_chan_if.gen  ch
);
   ilcc_gen_state_e state_q;
   logic [2:0]      idx_q;
   logic [2:0]      top_idx;

   // Top bit index is length minus one: 4, 5, 6 or 7.
   assign top_idx = 3'(3'h4 + {1'b0, ch.gen_len});
   assign ch.busy = (state_q == ILCC_SEND);

   // ------------------------------------------------------------------------
   // Serialiser
   // ------------------------------------------------------------------------
   // A new length takes effect at the next repetition boundary, but a new pattern
   // is read bit by bit from gen_bits, so it can change a running repetition.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q     <= ILCC_IDLE;
         idx_q       <= 3'h0;
         ch.tx_bit   <= 1'b0;
         ch.tx_valid <= 1'b0;
      end else if (clk_en) begin
         case (state_q)
            ILCC_IDLE: begin
               ch.tx_valid <= 1'b0;
               if (ch.gen_en) begin
                  state_q <= ILCC_SEND;
                  idx_q   <= top_idx;
               end
            end
            ILCC_SEND: begin
               ch.tx_bit   <= ch.gen_bits[idx_q];
               ch.tx_valid <= 1'b1;
               if (idx_q != 3'h0) begin
                  idx_q <= idx_q - 3'h1;
               end else if (ch.gen_en) begin
                  idx_q <= top_idx;
               end else begin
                  state_q <= ILCC_IDLE;
               end
            end
            default: begin
               state_q <= ILCC_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> ilcc_bank.sv
`default_nettype none
`include "ilcc_defs.svh"
module ilcc_bank
   import ilcc_pkg::*;
#(
   parameter int NUM_CHAN = 4
)(
   // Clock, reset and enable
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  clk_en,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [13:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Per-channel settings to the detectors
   output logic      [NUM_CHAN*2-1:0] act_len,
   output logic      [NUM_CHAN*2-1:0] deact_len,
   output logic      [NUM_CHAN*8-1:0] act_mask,
   output logic      [NUM_CHAN*8-1:0] act_bits,
   // Per-channel generated code
   output logic      [NUM_CHAN-1:0]   tx_bit,
   output logic      [NUM_CHAN-1:0]   tx_valid
);
   initial begin
      if (NUM_CHAN < 1 || NUM_CHAN > 28) begin
         $error("NUM_CHAN must lie between 1 and 28");
      end
   end

   // ------------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------------
   logic [11:0] idx;
   logic [5:0]  reg_off;
   logic [5:0]  chan_sel;
   logic        aligned;
   logic        in_range;
   logic        access;
   logic        wr_en;

   assign idx      = paddr[13:2];
   assign aligned  = (paddr[1:0] == 2'b00);
   assign chan_sel = 6'((idx - `ILCC_CHAN_BASE) >> 6);
   assign reg_off  = 6'(idx - `ILCC_CHAN_BASE);
   assign in_range = (idx >= `ILCC_CHAN_BASE) && (32'(chan_sel) < NUM_CHAN);
   assign access   = psel && !penable;
   assign wr_en    = psel && penable && pwrite && pready && !pslverr;

   logic [NUM_CHAN*8-1:0] rd_vec;
   logic [NUM_CHAN-1:0]   hit_vec;

   // ------------------------------------------------------------------------
   // Per-channel register copies
   // ------------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_CHAN; g++) begin : g_chan
         ilcc_chan_if ch ();
         logic [7:0] lengths_q;
         logic [7:0] gen_bits_q;
         logic [7:0] act_bits_q;
         logic       gen_en_q;
         logic       sel;
         logic [7:0] rd;
         logic       hit;
         logic [2:0] act_top;

         assign sel = in_range && (32'(chan_sel) == g);

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lengths_q  <= `ILCC_RST_LENGTHS;
               gen_bits_q <= `ILCC_RST_GEN_BITS;
               act_bits_q <= `ILCC_RST_ACT_BITS;
               gen_en_q   <= 1'b0;
            end else if (clk_en && wr_en && sel) begin
               case (reg_off[5:0] + 6'h00)
                  6'(`ILCC_IDX_LENGTHS - `ILCC_CHAN_BASE): begin
                     lengths_q <= {2'b00, pwdata[5:0]};
                  end
                  6'(`ILCC_IDX_GEN_BITS - `ILCC_CHAN_BASE): begin
                     gen_bits_q <= pwdata[7:0];
                  end
                  6'(`ILCC_IDX_ACT_BITS - `ILCC_CHAN_BASE): begin
                     act_bits_q <= pwdata[7:0];
                  end
                  6'(`ILCC_IDX_GEN_CTRL - `ILCC_CHAN_BASE): begin
                     gen_en_q <= pwdata[`ILCC_GEN_EN_BIT];
                  end
                  default: begin
                  end
               endcase
            end
         end

         assign ch.gen_len  = lengths_q[`ILCC_GEN_LEN_LSB +: 2];
         assign ch.gen_bits = gen_bits_q;
         assign ch.gen_en   = gen_en_q;

         ilcc_code_gen u_gen (
            .pclk    (pclk),
            .presetn (presetn),
            .clk_en  (clk_en),
            .ch      (ch.gen)
         );

         // Activate mask keeps only the valid low bits of the target code.
         assign act_top = 3'(3'h4 + {1'b0, lengths_q[`ILCC_ACT_LEN_LSB +: 2]});
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               act_len[g*2 +: 2]   <= 2'b00;
               deact_len[g*2 +: 2] <= 2'b01;
               act_mask[g*8 +: 8]  <= 8'h1F;
               act_bits[g*8 +: 8]  <= 8'h00;
               tx_bit[g]           <= 1'b0;
               tx_valid[g]         <= 1'b0;
            end else if (clk_en) begin
               act_len[g*2 +: 2]   <= lengths_q[`ILCC_ACT_LEN_LSB +: 2];
               deact_len[g*2 +: 2] <= lengths_q[`ILCC_DEACT_LEN_LSB +: 2];
               act_mask[g*8 +: 8]  <= 8'((9'h002 << act_top) - 9'h001);
               act_bits[g*8 +: 8]  <= act_bits_q;
               tx_bit[g]           <= ch.tx_bit;
               tx_valid[g]         <= ch.tx_valid;
            end
         end

         always_comb begin
            hit = 1'b1;
            rd  = 8'h00;
            case (reg_off)
               6'(`ILCC_IDX_LENGTHS - `ILCC_CHAN_BASE): rd = lengths_q;
               6'(`ILCC_IDX_GEN_BITS - `ILCC_CHAN_BASE): rd = gen_bits_q;
               6'(`ILCC_IDX_ACT_BITS - `ILCC_CHAN_BASE): rd = act_bits_q;
               6'(`ILCC_IDX_GEN_CTRL - `ILCC_CHAN_BASE): rd = {6'h00, ch.busy, gen_en_q};
               default: hit = 1'b0;
            endcase
         end
         assign rd_vec[g*8 +: 8] = sel ? rd : 8'h00;
         assign hit_vec[g]       = sel && hit;
      end
   endgenerate

   // ------------------------------------------------------------------------
   // Read mux and bus answer
   // ------------------------------------------------------------------------
   logic [7:0] rd_or;
   always_comb begin
      rd_or = 8'h00;
      for (int i = 0; i < NUM_CHAN; i++) begin
         rd_or = rd_or | rd_vec[i*8 +: 8];
      end
   end

   // No wait state: setup latches the answer, the first access cycle completes it.
   // Unmapped or unaligned addresses answer with an error and no write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready  <= access;
         pslverr <= access && !(aligned && (|hit_vec));
         prdata  <= (access && !pwrite && aligned && (|hit_vec)) ?
                    {24'h00_0000, rd_or} : 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// >>> ilcc_bank_asserts.sv
`default_nettype none
`include "ilcc_defs.svh"
module ilcc_bank_asserts
   import ilcc_pkg::*;
#(
   parameter int NUM_CHAN = 4
)(
   // Clock and bus
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [13:0]           paddr,
   input wire logic [31:0]           pwdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   // Channel settings and generated code valid
   input wire logic [NUM_CHAN*2-1:0] act_len,
   input wire logic [NUM_CHAN*2-1:0] deact_len,
   input wire logic [NUM_CHAN*8-1:0] act_mask,
   input wire logic [NUM_CHAN-1:0]   tx_valid
);
   localparam logic [13:0] LEN0 = {`ILCC_IDX_LENGTHS, 2'b00};
   wire logic wr_ok = psel & penable & pwrite & pready & ~pslverr;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence len0_wr_s;
      wr_ok && paddr == LEN0;
   endsequence
   reset_len_a: assert property (
      $rose(presetn) |-> deact_len[1:0] == 2'b01 && act_len[1:0] == 2'b00)
      else $error("length fields wrong after reset");
   answer_a: assert property (setup_s |=> pready) else $error("no answer after setup");
   pulse_a: assert property (pready |=> !pready) else $error("ready longer than a cycle");
   refuse_a: assert property (setup_s and paddr[1:0] != 2'b00 |=> pslverr)
      else $error("unaligned access not refused");
   act_wr_a: assert property (
      len0_wr_s |-> ##2 act_len[1:0] == $past(pwdata[3:2], 2))
      else $error("activate length lost");
   deact_wr_a: assert property (
      len0_wr_s |-> ##2 deact_len[1:0] == $past(pwdata[1:0], 2))
      else $error("deactivate length lost");
   chan_isolate_a: assert property (
      wr_ok && paddr != LEN0 |=> $stable(act_len[1:0]) && $stable(deact_len[1:0]))
      else $error("channel zero lengths disturbed");
   act_mask_a: assert property (
      act_mask[7:0] == 8'hFF >> (3 - act_len[1:0])) else $error("activate mask wrong");
   code_run_a: assert property (
      $rose(tx_valid[0]) |-> tx_valid[0] [*5]) else $error("code run broken");
endmodule
bind ilcc_bank ilcc_bank_asserts #(.NUM_CHAN(NUM_CHAN)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .act_len(act_len),
   .deact_len(deact_len), .act_mask(act_mask), .tx_valid(tx_valid));
`default_nettype wire

// >>> ilcc_line_rx.sv
`default_nettype none
module ilcc_line_rx (
   // Clock and clear
   input  wire logic        pclk,
   input  wire logic        clr,
   // Serial line from the generator
   input  wire logic        bit_in,
   input  wire logic        valid_in,
   output logic      [15:0] word,
   output logic      [4:0]  count
);
   timeunit 1ns;
   timeprecision 1ps;
   // This end only shifts while bits are flagged valid, so gaps add nothing to word or count.
   always_ff @(posedge pclk) begin
      if (clr) begin
         word  <= '0;
         count <= '0;
      end else if (valid_in) begin
         word  <= {word[14:0], bit_in};
         count <= count + 5'h1;
      end
   end
endmodule
`default_nettype wire

// >>> test_inband_loop_code_config.sv
`default_nettype none
`include "ilcc_defs.svh"
module test_inband_loop_code_config;
   import ilcc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, clr;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed, act_mask, act_bits;
   logic [7:0] act_len, deact_len, el[4], ea[4];
   logic [3:0] tx_bit, tx_valid;
   logic [15:0] word;
   logic [4:0] cnt;
   int fail_count, compares, n, k;
   ilcc_bank #(.NUM_CHAN(4)) i_ilcc_bank (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .act_len(act_len),
      .deact_len(deact_len), .act_mask(act_mask), .act_bits(act_bits), .tx_bit(tx_bit),
      .tx_valid(tx_valid));
   ilcc_line_rx i_ilcc_line_rx (.pclk(pclk), .clr(clr), .bit_in(tx_bit[0]),
      .valid_in(tx_valid[0]), .word(word), .count(cnt));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [13:0] ad(int c, int o);
      return {12'(`ILCC_IDX_LENGTHS + `ILCC_CHAN_STRIDE * c + o), 2'b00};
   endfunction
   function automatic logic [15:0] rep(logic [7:0] p, int m);
      logic [15:0] v;
      v = '0;
      for (int i = 0; i < m; i++) begin
         v[i] = p[i];
         v[i + m] = p[i];
      end
      return v;
   endfunction
   task automatic summarize();
      $display("counts: %0d compares, %0d mismatches", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(logic w, logic [13:0] a, logic [31:0] d);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      if (t == 20) chk("bus timeout", 0, 1);
      if (t == 20) summarize();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(logic [13:0] a, logic [7:0] e, logic ee);
      apb(1'b0, a, 32'h0);
      chk("read data", {24'h0, e}, rd);
      chk("read error", {31'h0, ee}, {31'h0, err});
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, fail_count, compares} = '0;
      clr = 1'b1;
      seed = 32'h40B8;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         rdc(ad(c, 0), 8'h01, 1'b0);
         rdc(ad(c, 1), 8'h01, 1'b0);
         rdc(ad(c, 2), 8'h00, 1'b0);
      end
      $display("test reset done");
      // Rounds 0 and 1 are the all-ones and all-zeros corners, the rest random.
      for (int r = 0; r < 4; r++) begin
         for (int c = 0; c < 4; c++) begin
            seed = lfsr(seed);
            el[c] = r == 0 ? 8'hFF : r == 1 ? 8'h00 : seed[7:0];
            ea[c] = r == 0 ? 8'hFF : r == 1 ? 8'h00 : seed[15:8];
            apb(1'b1, ad(c, 0), {24'h0, el[c]});
            apb(1'b1, ad(c, 2), {24'h0, ea[c]});
         end
         for (int c = 0; c < 4; c++) begin
            rdc(ad(c, 0), el[c] & 8'h3F, 1'b0);
            rdc(ad(c, 2), ea[c], 1'b0);
            chk("act_len", {30'h0, el[c][3:2]}, {30'h0, act_len[2*c+:2]});
            chk("deact_len", {30'h0, el[c][1:0]}, {30'h0, deact_len[2*c+:2]});
            chk("act_bits", {24'h0, ea[c]}, {24'h0, act_bits[8*c+:8]});
            chk("act_mask", {24'h0, 8'(8'hFF >> (2'd3 - el[c][3:2]))}, {24'h0, act_mask[8*c+:8]});
         end
      end
      $display("test registers done");
      apb(1'b1, ad(0, 0) + 14'h1, 32'h3F);
      rdc(ad(0, 0) + 14'h1, 8'h00, 1'b1);
      rdc(ad(0, 4), 8'h00, 1'b1);
      rdc(ad(4, 0), 8'h00, 1'b1);
      rdc(ad(0, 0), el[0] & 8'h3F, 1'b0);
      $display("test refusal done");
      for (int l = 0; l < 4; l++) begin
         n = 5 + l;
         seed = lfsr(seed);
         apb(1'b1, ad(0, 0), {26'h0, 2'(l), 4'h5});
         apb(1'b1, ad(0, 1), seed);
         clr <= 1'b1;
         @(posedge pclk);
         clr <= 1'b0;
         apb(1'b1, ad(0, 3), 32'h1);
         k = 0;
         while (cnt < 2 * n && k < 200) begin
            @(posedge pclk);
            k++;
         end
         chk("serial", {16'h0, rep(seed[7:0], n)}, {16'h0, word & 16'((1 << 2 * n) - 1)});
         apb(1'b1, ad(0, 3), 32'h0);
         k = 0;
         while (tx_valid[0] !== 1'b0 && k < 40) begin
            @(posedge pclk);
            k++;
         end
         chk("stop", 32'h0, {31'h0, tx_valid[0]});
      end
      $display("test generator done");
      summarize();
   end
endmodule
`default_nettype wire
